/* File: src/ext_edge_flags_and_page_regs.sv */
`timescale 1ns/100ps
// How it works
// - Flag for line five (bit 7) is set on a falling edge of its pin.
// - Flag for line four (bit 6) is set on a rising edge of its pin.
// - Flag for line three (bit 5) is set on a falling edge of its pin.
// - Flag for line two (bit 4) is set on a rising edge of its pin.
// - A flag stays set until software writes zero to it; hardware never clears it.
// - Writing one to a flag sets it, the same as an edge on its pin does.
// - A falling edge on the trigger pin with trigger enabled and auto-reload off copies the count to capture.
// - In auto-reload mode that trigger edge loads the count from the reload bytes.
// - A falling edge on the count pin steps the timer up or down by one, unless an auto-reload trigger edge lands in the same cycle.
// - Indirect external moves take their upper address byte from the page register.
// - The configuration address register addresses the 128-byte configuration memory.
// - The configuration address register is write-only and reads back zero.
// - The configuration data register returns the byte at the last written address.
module ext_edge_flags_and_page_regs (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   // Register bus
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic        i_sfr_rd,
   input  wire logic [7:0]  i_sfr_wdata,
   output logic      [7:0]  o_sfr_rdata,
   // Interrupt pins, index 0..3 = lines two..five
   input  wire logic [3:0]  i_irq_pins,
   output logic      [3:0]  o_edge_flags,
   // Second timer pins and controls
   input  wire logic        i_timer_b_trigger_pin,
   input  wire logic        i_timer_b_count_pin,
   input  wire logic        i_timer_b_ext_trigger_enable,
   input  wire logic        i_timer_b_auto_reload,
   input  wire logic        i_timer_b_count_down,
   input  wire logic [15:0] i_timer_b_count,
   input  wire logic [7:0]  i_timer_b_reload_low,
   input  wire logic [7:0]  i_timer_b_reload_high,
   output logic             o_timer_b_capture,
   output logic      [15:0] o_timer_b_capture_value,
   output logic             o_timer_b_reload,
   output logic             o_timer_b_count_step,
   output logic      [15:0] o_timer_b_next_count,
   // External data move address
   input  wire logic        i_indirect_move,
   input  wire logic [7:0]  i_port2_latch,
   input  wire logic [7:0]  i_move_addr_low,
   output logic      [15:0] o_move_addr,
   // Configuration memory contents
   input  wire logic [1023:0] i_cfg_mem,
   output logic      [6:0]  o_cfg_addr
);

   typedef struct packed {
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
      logic [3:0]  pin_s3;
      logic        trig_s1;
      logic        trig_s2;
      logic        trig_s3;
      logic        cnt_s1;
      logic        cnt_s2;
      logic        cnt_s3;
      logic [3:0]  flags;
      logic [7:0]  page;
      logic [7:0]  cfg_addr;
      logic [7:0]  cfg_data;
      logic        capture;
      logic [15:0] capture_value;
      logic        reload;
      logic        step;
      logic [15:0] next_count;
      logic [7:0]  rdata;
   } state_t;

   typedef enum logic [1:0] {
      TRIG_IDLE    = 2'b00,
      TRIG_CAPTURE = 2'b01,
      TRIG_RELOAD  = 2'b10
   } trig_t;

   state_t s_r;
   state_t s_nxt;
   trig_t  trig_kind;

   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic [3:0] hw_set;
   logic       trig_fall;
   logic       cnt_fall;
   logic       wr_flags;

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection per interrupt line
   genvar g;
   generate
      for (g = 0; g < ext_flags_pkg::FLAG_CNT; g++) begin : g_line
         assign pin_rise[g] = s_r.pin_s2[g] & ~s_r.pin_s3[g];
         assign pin_fall[g] = ~s_r.pin_s2[g] & s_r.pin_s3[g];
         // Lines four and two see rising edges, five and three falling
         assign hw_set[g] = ext_flags_pkg::FLAG_RISING[g] ? pin_rise[g]
                                                          : pin_fall[g];
      end
   endgenerate

   // Timer pins are compared past the synchroniser, like the interrupt lines
   assign trig_fall = ~s_r.trig_s2 & s_r.trig_s3;
   assign cnt_fall  = ~s_r.cnt_s2 & s_r.cnt_s3;
   assign wr_flags  = i_sfr_wr && (i_sfr_addr == ext_flags_pkg::ADDR_EDGE_FLAGS);

   always_comb begin
      if (trig_fall && i_timer_b_ext_trigger_enable) begin
         trig_kind = i_timer_b_auto_reload ? TRIG_RELOAD : TRIG_CAPTURE;
      end else begin
         trig_kind = TRIG_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_nxt = s_r;
      // Two stages synchronise each pin; the third holds the previous sample
      s_nxt.pin_s1  = i_irq_pins;
      s_nxt.pin_s2  = s_r.pin_s1;
      s_nxt.pin_s3  = s_r.pin_s2;
      s_nxt.trig_s1 = i_timer_b_trigger_pin;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_s3 = s_r.trig_s2;
      s_nxt.cnt_s1  = i_timer_b_count_pin;
      s_nxt.cnt_s2  = s_r.cnt_s1;
      s_nxt.cnt_s3  = s_r.cnt_s2;

      // Software writes the flag field; hardware edges override a clear
      if (wr_flags) begin
         s_nxt.flags = i_sfr_wdata[ext_flags_pkg::FLAG_LSB +: ext_flags_pkg::FLAG_CNT];
      end
      s_nxt.flags = s_nxt.flags | hw_set;

      if (i_sfr_wr && (i_sfr_addr == ext_flags_pkg::ADDR_DATA_PAGE)) begin
         s_nxt.page = i_sfr_wdata;
      end
      if (i_sfr_wr && (i_sfr_addr == ext_flags_pkg::ADDR_CFG_ADDRESS)) begin
         s_nxt.cfg_addr = i_sfr_wdata;
      end
      // Data register follows the last written address, upper bit ignored
      s_nxt.cfg_data = i_cfg_mem[s_nxt.cfg_addr[ext_flags_pkg::CFG_AW-1:0] *
                                 ext_flags_pkg::CFG_BYTE_W +: ext_flags_pkg::CFG_BYTE_W];

      s_nxt.capture = 1'b0;
      s_nxt.reload  = 1'b0;
      case (trig_kind)
         TRIG_CAPTURE: begin
            s_nxt.capture       = 1'b1;
            s_nxt.capture_value = i_timer_b_count;
         end
         TRIG_RELOAD: begin
            s_nxt.reload     = 1'b1;
            s_nxt.next_count = {i_timer_b_reload_high, i_timer_b_reload_low};
         end
         default: begin
         end
      endcase

      s_nxt.step = cnt_fall;
      if (cnt_fall && (trig_kind != TRIG_RELOAD)) begin
         s_nxt.next_count = i_timer_b_count_down ?
                            i_timer_b_count - ext_flags_pkg::TIMER_STEP :
                            i_timer_b_count + ext_flags_pkg::TIMER_STEP;
      end

      s_nxt.rdata = ext_flags_pkg::READ_ZERO;
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            ext_flags_pkg::ADDR_EDGE_FLAGS:
               s_nxt.rdata = {s_r.flags, ext_flags_pkg::FLAG_FIXED_BITS[3:0]};
            ext_flags_pkg::ADDR_DATA_PAGE:   s_nxt.rdata = s_r.page;
            ext_flags_pkg::ADDR_CFG_ADDRESS: s_nxt.rdata = ext_flags_pkg::READ_ZERO;
            ext_flags_pkg::ADDR_CFG_DATA:    s_nxt.rdata = s_r.cfg_data;
            default:                         s_nxt.rdata = ext_flags_pkg::READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         s_r          <= '0;
         // Stages start at the live pin level, so release shows no false edge
         s_r.pin_s1   <= i_irq_pins;
         s_r.pin_s2   <= i_irq_pins;
         s_r.pin_s3   <= i_irq_pins;
         s_r.trig_s1  <= i_timer_b_trigger_pin;
         s_r.trig_s2  <= i_timer_b_trigger_pin;
         s_r.trig_s3  <= i_timer_b_trigger_pin;
         s_r.cnt_s1   <= i_timer_b_count_pin;
         s_r.cnt_s2   <= i_timer_b_count_pin;
         s_r.cnt_s3   <= i_timer_b_count_pin;
         s_r.flags    <= ext_flags_pkg::RST_EDGE_FLAGS[7:4];
         s_r.page     <= ext_flags_pkg::RST_DATA_PAGE;
         s_r.cfg_addr <= ext_flags_pkg::RST_CFG_ADDRESS;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_sfr_rdata             = s_r.rdata;
   assign o_edge_flags            = s_r.flags;
   assign o_timer_b_capture       = s_r.capture;
   assign o_timer_b_capture_value = s_r.capture_value;
   assign o_timer_b_reload        = s_r.reload;
   assign o_timer_b_count_step    = s_r.step;
   assign o_timer_b_next_count    = s_r.next_count;
   assign o_cfg_addr              = s_r.cfg_addr[ext_flags_pkg::CFG_AW-1:0];
   // Upper byte from the page register for indirect moves
   assign o_move_addr = {(i_indirect_move ? s_r.page : i_port2_latch), i_move_addr_low};

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   flag_five_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_fall[3] |=> s_r.flags[3]) else $error("line five edge lost");
   flag_four_rise_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_rise[2] |=> s_r.flags[2]) else $error("line four edge lost");
   flag_three_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_fall[1] |=> s_r.flags[1]) else $error("line three edge lost");
   flag_two_rise_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_rise[0] |=> s_r.flags[0]) else $error("line two edge lost");
   flag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (!wr_flags ##1 1'b1) |-> ($past(s_r.flags) & ~s_r.flags) == 4'h0)
      else $error("flag dropped without write");
   flag_sw_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flags && i_sfr_wdata[7] |=> o_edge_flags[3]) else $error("software set failed");
   capture_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      trig_fall && i_timer_b_ext_trigger_enable && !i_timer_b_auto_reload
      |=> o_timer_b_capture && o_timer_b_capture_value == $past(i_timer_b_count))
      else $error("capture missed");
   reload_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_timer_b_reload |-> $past(i_timer_b_ext_trigger_enable && i_timer_b_auto_reload))
      else $error("reload without enable");
   count_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_fall |=> o_timer_b_count_step) else $error("count step missed");
   move_page_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_indirect_move |-> o_move_addr[15:8] == s_r.page) else $error("page not used");
   cfg_wo_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sfr_rd && i_sfr_addr == ext_flags_pkg::ADDR_CFG_ADDRESS |=> o_sfr_rdata == 8'h00)
      else $error("address register readable");
   reset_clear_a: assert property (@(posedge i_clk_sys)
      !i_rst_b |=> o_edge_flags == 4'h0 && o_cfg_addr == 7'h00) else $error("reset value");

   // Flag register writes and reads
   sw_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flags && hw_set == 4'h0 |=> o_edge_flags ==
         $past(i_sfr_wdata[ext_flags_pkg::FLAG_LSB +: ext_flags_pkg::FLAG_CNT]))
      else $error("flag write not applied");
   set_beats_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flags && hw_set != 4'h0 |=> (o_edge_flags & $past(hw_set)) == $past(hw_set))
      else $error("edge lost to clear");
   flag_readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sfr_rd && i_sfr_addr == ext_flags_pkg::ADDR_EDGE_FLAGS |=>
      o_sfr_rdata == {$past(o_edge_flags), ext_flags_pkg::FLAG_FIXED_BITS[3:0]})
      else $error("flag readback wrong");

   // Timer pin results
   trig_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      trig_fall && !i_timer_b_ext_trigger_enable |=> !o_timer_b_capture && !o_timer_b_reload)
      else $error("trigger acted while disabled");
   capture_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      !o_timer_b_capture |-> $stable(o_timer_b_capture_value))
      else $error("capture value moved");
   reload_value_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_timer_b_reload |-> o_timer_b_next_count == $past({i_timer_b_reload_high, i_timer_b_reload_low}))
      else $error("reload value wrong");
   step_up_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_fall && !i_timer_b_count_down && trig_kind != TRIG_RELOAD |=>
      o_timer_b_next_count == $past(i_timer_b_count) + ext_flags_pkg::TIMER_STEP)
      else $error("count up wrong");
   step_down_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_fall && i_timer_b_count_down && trig_kind != TRIG_RELOAD |=>
      o_timer_b_next_count == $past(i_timer_b_count) - ext_flags_pkg::TIMER_STEP)
      else $error("count down wrong");
   count_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      !o_timer_b_reload && !o_timer_b_count_step |-> $stable(o_timer_b_next_count))
      else $error("next count moved");

   // Page, configuration address and configuration data
   page_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sfr_wr && i_sfr_addr == ext_flags_pkg::ADDR_DATA_PAGE |=> s_r.page == $past(i_sfr_wdata))
      else $error("page write lost");
   cfg_addr_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sfr_wr && i_sfr_addr == ext_flags_pkg::ADDR_CFG_ADDRESS |=>
      o_cfg_addr == $past(i_sfr_wdata[ext_flags_pkg::CFG_AW-1:0]))
      else $error("config address wrong");
   cfg_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sfr_rd && i_sfr_addr == ext_flags_pkg::ADDR_CFG_DATA |=> o_sfr_rdata ==
         $past(i_cfg_mem[o_cfg_addr * ext_flags_pkg::CFG_BYTE_W +: ext_flags_pkg::CFG_BYTE_W]))
      else $error("config data mismatch");

   edge_set_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) |hw_set);
   set_vs_clear_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flags && |hw_set);
   capture_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_timer_b_capture);
   reload_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_timer_b_reload);
   step_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_timer_b_count_step);

endmodule // ext_edge_flags_and_page_regs

/* File: src/ext_flags_pkg.sv */
package ext_flags_pkg;
   // Register locations on the special-function bus
   localparam logic [7:0] ADDR_EDGE_FLAGS  = 8'h91;
   localparam logic [7:0] ADDR_DATA_PAGE   = 8'h92;
   localparam logic [7:0] ADDR_CFG_ADDRESS = 8'h93;
   localparam logic [7:0] ADDR_CFG_DATA    = 8'h94;
   // Reset values
   localparam logic [7:0] RST_EDGE_FLAGS   = 8'h08;
   localparam logic [7:0] RST_DATA_PAGE    = 8'h00;
   localparam logic [7:0] RST_CFG_ADDRESS  = 8'h00;
   // Flag field: bits 7..4, bit 3 reads one, bits 2..0 read zero
   localparam int         FLAG_LSB         = 4;
   localparam int         FLAG_CNT         = 4;
   localparam logic [3:0] FLAG_RISING      = 4'h5;
   localparam logic [7:0] FLAG_FIXED_BITS  = 8'h08;
   // Configuration memory depth and address width
   localparam int         CFG_DEPTH        = 128;
   localparam int         CFG_AW           = 7;
   localparam int         CFG_BYTE_W       = 8;
   localparam logic [7:0] READ_ZERO        = 8'h00;
   localparam logic [15:0] TIMER_STEP      = 16'h0001;
endpackage

/* File: verif/ext_edge_flags_and_page_regs_tb_top.sv */
`timescale 1ns/100ps
module ext_edge_flags_and_page_regs_tb_top;
   logic clk, rst_b, wr, rd, en, auto, down, mv, trq, crq, trp, cnp, cap, rel, stp;
   logic [7:0]    addr, wd, rdat, rl, rh, p2, lo;
   logic [3:0]    irq, pins, flags;
   logic [15:0]   cnt, capv, nxt, maddr;
   logic [1023:0] mem;
   logic [6:0]    config_memory_address;
   int            fail_count, checked;

   ext_pin_partner u_partner (.i_clk_sys(clk), .i_irq_req(irq), .i_trig_req(trq),
      .i_cnt_req(crq), .o_irq_pins(pins), .o_trig_pin(trp), .o_cnt_pin(cnp), .o_cfg_mem(mem));
   ext_edge_flags_and_page_regs u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_sfr_addr(addr),
      .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdat), .i_irq_pins(pins),
      .o_edge_flags(flags), .i_timer_b_trigger_pin(trp), .i_timer_b_count_pin(cnp),
      .i_timer_b_ext_trigger_enable(en), .i_timer_b_auto_reload(auto),
      .i_timer_b_count_down(down), .i_timer_b_count(cnt), .i_timer_b_reload_low(rl),
      .i_timer_b_reload_high(rh), .o_timer_b_capture(cap), .o_timer_b_capture_value(capv),
      .o_timer_b_reload(rel), .o_timer_b_count_step(stp), .o_timer_b_next_count(nxt),
      .i_indirect_move(mv), .i_port2_latch(p2), .i_move_addr_low(lo), .o_move_addr(maddr),
      .i_cfg_mem(mem), .o_cfg_addr(config_memory_address));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(16'(rdat), 16'(e));
   endtask
   // Counts timer pulses over the edge latency window
   task automatic watch(input int ec, input int er, input int es);
      int c, r, s;
      c = 0; r = 0; s = 0;
      repeat (8) begin
         @(posedge clk); #1;
         if (cap === 1'b1) c++;
         if (rel === 1'b1) r++;
         if (stp === 1'b1) s++;
      end
      chk(16'(c), 16'(ec)); chk(16'(r), 16'(er)); chk(16'(s), 16'(es));
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
   initial begin
      rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wd = 8'h00; irq = 4'ha;
      trq = 1'b1; crq = 1'b1; en = 1'b1; auto = 1'b0; down = 1'b0; cnt = 16'h1234;
      rl = 8'h78; rh = 8'h56; mv = 1'b0; p2 = 8'hc3; lo = 8'h3c;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rdc(8'h91, 8'h08);
      rdc(8'h92, 8'h00);
      rdc(8'h93, 8'h00);
      rdc(8'h95, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) irq[i] <= ~irq[i];
         repeat (6) @(posedge clk);
         #1 chk(16'(flags), 16'((5'h01 << (i + 1)) - 5'h01));
      end
      rdc(8'h91, 8'hf8);
      wrt(8'h91, 8'h00);
      rdc(8'h91, 8'h08);
      @(posedge clk) irq <= 4'ha;
      repeat (6) @(posedge clk);
      #1 chk(16'(flags), 16'h0000);
      wrt(8'h91, 8'h5f);
      rdc(8'h91, 8'h58);
      wrt(8'h91, 8'ha0);
      rdc(8'h91, 8'ha8);
      // Line two edge lands in the same cycle as a write of zero
      @(posedge clk) irq[0] <= ~irq[0];
      repeat (2) @(posedge clk);
      wrt(8'h91, 8'h00);
      rdc(8'h91, 8'h18);
      $display("test edge flags done");
      wrt(8'h92, 8'h5a);
      @(posedge clk) mv <= 1'b1;
      @(posedge clk) #1 chk(maddr, 16'h5a3c);
      @(posedge clk) mv <= 1'b0;
      @(posedge clk) #1 chk(maddr, 16'hc33c);
      rdc(8'h92, 8'h5a);
      wrt(8'h93, 8'h85);
      rdc(8'h93, 8'h00);
      chk(16'(config_memory_address), 16'h0005);
      rdc(8'h94, 8'ha0);
      wrt(8'h93, 8'h7f);
      rdc(8'h94, 8'hda);
      $display("test page and config done");
      @(posedge clk) trq <= 1'b0;
      watch(1, 0, 0);
      chk(capv, 16'h1234);
      @(posedge clk) trq <= 1'b1;
      watch(0, 0, 0);
      @(posedge clk) begin
         auto <= 1'b1;
         trq <= 1'b0;
      end
      watch(0, 1, 0);
      chk(nxt, 16'h5678);
      @(posedge clk) begin
         trq <= 1'b1;
         en <= 1'b0;
      end
      watch(0, 0, 0);
      @(posedge clk) trq <= 1'b0;
      watch(0, 0, 0);
      @(posedge clk) crq <= 1'b0;
      watch(0, 0, 1);
      chk(nxt, 16'h1235);
      @(posedge clk) begin
         crq <= 1'b1;
         down <= 1'b1;
      end
      watch(0, 0, 0);
      @(posedge clk) crq <= 1'b0;
      watch(0, 0, 1);
      chk(nxt, 16'h1233);
      $display("test timer pins done");
      final_report();
   end
endmodule // ext_edge_flags_and_page_regs_tb_top

/* File: verif/ext_pin_partner.sv */
`timescale 1ns/100ps
module ext_pin_partner (
   // Clock
   input  wire logic          i_clk_sys,
   // Requested pin levels
   input  wire logic [3:0]    i_irq_req,
   input  wire logic          i_trig_req,
   input  wire logic          i_cnt_req,
   // Pins and configuration memory
   output logic      [3:0]    o_irq_pins,
   output logic               o_trig_pin,
   output logic               o_cnt_pin,
   output logic      [1023:0] o_cfg_mem
);
   // Pins move one edge after a request; callers hold levels many cycles
   always_ff @(posedge i_clk_sys) begin
      o_irq_pins <= i_irq_req;
      o_trig_pin <= i_trig_req;
      o_cnt_pin  <= i_cnt_req;
   end
   // Every byte differs, so a wrong address shows
   always_comb begin
      for (int n = 0; n < 128; n++) begin
         o_cfg_mem[8*n +: 8] = 8'(n) ^ 8'ha5;
      end
   end
endmodule // ext_pin_partner
